// ### verilog/tdc_pkg.sv
package tdc_pkg;

  // ----------------------------------------------------------------
  // Operating modes of the measurement selector
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    TDC_MODE_BIAS = 3'h0,
    TDC_MODE_END = 3'h1,
    TDC_MODE_PEAK_TOTAL = 3'h2,
    TDC_MODE_PEAK_EARLY = 3'h3,
    TDC_MODE_PEAK_LATE = 3'h4
  } tdc_mode_t;

  // ----------------------------------------------------------------
  // Character timer states, Gray along stopped to running
  // ----------------------------------------------------------------
  typedef enum logic
  {
    TDC_CHAR_STOPPED = 1'b0,
    TDC_CHAR_RUNNING = 1'b1
  } tdc_char_t;

  // ----------------------------------------------------------------
  // Decade codes, stage order {d, c, b, a}, weights 2-4-2-1
  // ----------------------------------------------------------------
  localparam logic [3:0] DEC_0 = 4'h0;
  localparam logic [3:0] DEC_1 = 4'h1;
  localparam logic [3:0] DEC_2 = 4'h2;
  localparam logic [3:0] DEC_3 = 4'h3;
  localparam logic [3:0] DEC_4 = 4'h4;
  localparam logic [3:0] DEC_5 = 4'hB;
  localparam logic [3:0] DEC_6 = 4'hC;
  localparam logic [3:0] DEC_7 = 4'hD;
  localparam logic [3:0] DEC_8 = 4'hE;
  localparam logic [3:0] DEC_9 = 4'hF;
  localparam logic [3:0] DEC_PRESET = 4'hF;

  // ----------------------------------------------------------------
  // Bit counter, divider and register constants
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_PRESET = 4'hF;
  localparam logic [3:0] STOP_BASE = 4'h6;
  localparam logic [3:0] SEL_ALL = 4'h0;
  localparam logic [3:0] DIV_WRAP_50 = 4'hB;
  localparam logic [1:0] DIV_SEL_50 = 2'h3;
  localparam logic [7:0] REG_ZERO = 8'h00;
  localparam int REG_HALF_POS = 7;
  localparam int REG_FORTY_POS = 6;

  // Next state of a decade; illegal codes fall back to zero
  function automatic logic [3:0] decade_next(input logic [3:0] cur);
    logic [3:0] nxt;
    nxt = DEC_0;
    unique case (cur)
      DEC_0: nxt = DEC_1;
      DEC_1: nxt = DEC_2;
      DEC_2: nxt = DEC_3;
      DEC_3: nxt = DEC_4;
      DEC_4: nxt = DEC_5;
      DEC_5: nxt = DEC_6;
      DEC_6: nxt = DEC_7;
      DEC_7: nxt = DEC_8;
      DEC_8: nxt = DEC_9;
      DEC_9: nxt = DEC_0;
      default: nxt = DEC_0;
    endcase
    return nxt;
  endfunction : decade_next

  // Magnitude of seven stages weighted 1,2,4,2,10,20,40
  function automatic logic [6:0] stage_weight(input logic [6:0] st);
    logic [6:0] sum;
    sum = 7'(st[0]) + 7'({st[1], 1'b0}) + 7'({st[2], 2'b00}) + 7'({st[3], 1'b0});
    sum = sum + (st[4] ? 7'h0A : 7'h00) + (st[5] ? 7'h14 : 7'h00);
    sum = sum + (st[6] ? 7'h28 : 7'h00);
    return sum;
  endfunction : stage_weight

endpackage : tdc_pkg

// ### verilog/tdc_divider.sv
`timescale 1ns/1ps

module tdc_divider
#(
  parameter int DIV_WIDTH = 4
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] speed_sel_i,
  input wire logic baud50_i,
  output logic tick_o
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DIV_WIDTH != 4)
  begin : g_bad_width
    $error("tdc_divider serves exactly four stages");
  end

  logic [DIV_WIDTH-1:0] div_q;
  logic [DIV_WIDTH-1:0] div_d;
  logic sel_prev_q;
  logic sel_now;

  // Binary stages; the 50 baud cycle is cut from 16 counts to 12
  always_comb
  begin
    div_d = div_q + 4'h1;
    if (baud50_i && (div_q == tdc_pkg::DIV_WRAP_50))
    begin
      div_d = '0;
    end
  end

  // Divider stages run free on the oscillator
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_d;
    end
  end

  // 50 baud always takes the last stage so the shortened cycle is used
  assign sel_now = baud50_i ? div_q[tdc_pkg::DIV_SEL_50] : div_q[speed_sel_i];

  // Previous level of the chosen stage, for its falling edge
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sel_prev_q <= 1'b0;
    end
    else
    begin
      sel_prev_q <= sel_now;
    end
  end

  // One pulse per period of the chosen stage
  assign tick_o = sel_prev_q & ~sel_now;

endmodule : tdc_divider

// ### verilog/tdc_decade.sv
`timescale 1ns/1ps

module tdc_decade
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic preset_i,
  input wire logic advance_i,
  output logic [3:0] stage_o,
  output logic rise_o,
  output logic carry_o
);

  logic [3:0] stage_q;

  // Skip-gated count: 0100 goes straight to 1011; preset wins
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage_q <= tdc_pkg::DEC_PRESET;
    end
    else if (preset_i)
    begin
      stage_q <= tdc_pkg::DEC_PRESET;
    end
    else if (advance_i)
    begin
      stage_q <= tdc_pkg::decade_next(stage_q);
    end
  end

  assign stage_o = stage_q;
  // Last stage rises at 4 to 5 and falls at 9 to 0: ten per cycle
  assign rise_o = advance_i & ~preset_i & (stage_q == tdc_pkg::DEC_4);
  assign carry_o = advance_i & ~preset_i & (stage_q == tdc_pkg::DEC_9);

endmodule : tdc_decade

// ### verilog/tdc_capture.sv
// What this block does
// - Decades count 1-2-4-2, skipping from four to five
// - Captures read 0-49 late, 49-0 early
// - Mode picks which edge directions request captures
// - No capture at a character start edge
// - Second decade mirrors first, clocked by its carry
// - Bit counter steps on half-bit stage rising
// - Select decode gives one-bit capture window
// - Stop at 6.5 to 9.5 bits per code
// - Start edge presets countdown stages to one, not the divider
// - Late capture copies decade stages directly
// - Early capture inverts all but half stage
// - Seven stages weighted 1,2,4,2,10,20,40
// - Manual reset clears the capture register
// - Calibrate clears and sets weight-forty stage
// - Eighth stage records early or late half
// - Bias: early marks; end mode reversed
// - Early equality with complement sets peak flag
// - Late equality with register clears peak flag
// - Each comparator acts only in its half
// - Peak flag blocks captures in peak modes
// - Divider reduces oscillator, speed picks stage
// - 50 baud shortens divider cycle to twelve
// - Timing gate blocks pulses during stop interval
// - First stage clocks decades, clears request
`timescale 1ns/1ps

module tdc_capture
#(
  parameter int SYNC_STAGES = 2
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic line_mark_i,
  input wire logic [1:0] speed_sel_i,
  input wire logic baud50_i,
  input wire logic [1:0] code_level_i,
  input wire logic [3:0] transition_sel_i,
  input wire logic [2:0] measure_mode_i,
  input wire logic meter_zero_i,
  input wire logic meter_cal_i,
  output logic [7:0] capture_reg_o,
  output logic [6:0] distortion_pct_o,
  output logic marking_o,
  output logic spacing_o,
  output logic signal_mark_o,
  output logic running_o,
  output logic peak_gate_o,
  output logic capture_o
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (SYNC_STAGES < 2)
  begin : g_bad_sync
    $error("tdc_capture needs at least two synchroniser stages");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] line_sync_q;
  logic [SYNC_STAGES-1:0] zero_sync_q;
  logic [SYNC_STAGES-1:0] cal_sync_q;
  logic line_prev_q;
  logic line_now;
  logic edge_ms;
  logic edge_sm;
  logic div_tick;
  logic gated_tick;
  logic countdown_first_stage_q;
  logic dec_advance;
  logic [3:0] first_decade;
  logic [3:0] second_decade;
  logic first_carry;
  logic half_rise;
  logic half_bit_stage;
  logic [3:0] bit_count_q;
  tdc_pkg::tdc_char_t char_q;
  logic start_preset;
  logic stop_hit;
  logic transition_request_ff_q;
  logic req_set;
  logic req_clear;
  logic [6:0] count_low;
  logic [7:0] capture_q;
  logic [6:0] pct_q;
  logic peak_gate_flag_q;
  logic early_eq;
  logic late_eq;
  logic is_peak;
  logic start_block;
  logic window_ok;
  logic dir_ok;
  logic peak_ok;
  logic transfer;
  logic marking_q;
  logic spacing_q;
  logic mark_q;
  logic capture_q_pulse;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------

  // Two-flop chains; only the last stage is looked at
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      line_sync_q <= '1;
      zero_sync_q <= '0;
      cal_sync_q <= '0;
    end
    else
    begin
      line_sync_q <= {line_sync_q[SYNC_STAGES-2:0], line_mark_i};
      zero_sync_q <= {zero_sync_q[SYNC_STAGES-2:0], meter_zero_i};
      cal_sync_q <= {cal_sync_q[SYNC_STAGES-2:0], meter_cal_i};
    end
  end

  assign line_now = line_sync_q[SYNC_STAGES-1];

  // Regenerated signal copy for edges; the signal lamp has its own flop
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      line_prev_q <= 1'b1;
    end
    else
    begin
      line_prev_q <= line_now;
    end
  end

  assign edge_ms = line_prev_q & ~line_now;
  assign edge_sm = ~line_prev_q & line_now;

  // ----------------------------------------------------------------
  // Timing divider and gate
  // ----------------------------------------------------------------
  tdc_divider #(
    .DIV_WIDTH(4)
  ) u_divider (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .speed_sel_i(speed_sel_i),
    .baud50_i(baud50_i),
    .tick_o(div_tick)
  );

  // Pulses stop reaching the countdown while the character timer rests
  assign gated_tick = div_tick & (char_q == tdc_pkg::TDC_CHAR_RUNNING);

  // Half-rate first stage; a preset leaves it high like the decades
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      countdown_first_stage_q <= 1'b1;
    end
    else if (start_preset)
    begin
      countdown_first_stage_q <= 1'b1;
    end
    else if (gated_tick)
    begin
      countdown_first_stage_q <= ~countdown_first_stage_q;
    end
  end

  // Decades move when the first stage falls
  assign dec_advance = gated_tick & countdown_first_stage_q;

  // ----------------------------------------------------------------
  // Two decades of one hundred counts per bit
  // ----------------------------------------------------------------
  tdc_decade u_first_decade (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .preset_i(start_preset),
    .advance_i(dec_advance),
    .stage_o(first_decade),
    .rise_o(),
    .carry_o(first_carry)
  );

  // Same cell, clocked by the first decade's last stage
  tdc_decade u_second_decade (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .preset_i(start_preset),
    .advance_i(first_carry),
    .stage_o(second_decade),
    .rise_o(half_rise),
    .carry_o()
  );

  assign half_bit_stage = second_decade[3];
  assign count_low = {second_decade[2:0], first_decade};

  // ----------------------------------------------------------------
  // Bit counter and character timing
  // ----------------------------------------------------------------

  // Zero side of the half stage: boundaries land at mid-bit
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bit_count_q <= tdc_pkg::BIT_PRESET;
    end
    else if (start_preset)
    begin
      bit_count_q <= tdc_pkg::BIT_PRESET;
    end
    else if (half_rise)
    begin
      bit_count_q <= bit_count_q + 4'h1;
    end
  end

  // Stop count is 6 to 9 whole counts, i.e. 6.5 to 9.5 bits
  assign stop_hit = (bit_count_q == (tdc_pkg::STOP_BASE + {2'b00, code_level_i}));
  // Only a mark-to-space edge in the rest interval starts a character
  assign start_preset = (char_q == tdc_pkg::TDC_CHAR_STOPPED) & edge_ms;

  // Running until stop count, resting until the next start edge
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      char_q <= tdc_pkg::TDC_CHAR_STOPPED;
    end
    else
    begin
      unique case (char_q)
        tdc_pkg::TDC_CHAR_STOPPED:
        begin
          if (start_preset)
          begin
            char_q <= tdc_pkg::TDC_CHAR_RUNNING;
          end
        end
        tdc_pkg::TDC_CHAR_RUNNING:
        begin
          if (stop_hit)
          begin
            char_q <= tdc_pkg::TDC_CHAR_STOPPED;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transition request and capture steering
  // ----------------------------------------------------------------
  assign is_peak = (measure_mode_i == tdc_pkg::TDC_MODE_PEAK_TOTAL) |
                   (measure_mode_i == tdc_pkg::TDC_MODE_PEAK_EARLY) |
                   (measure_mode_i == tdc_pkg::TDC_MODE_PEAK_LATE);

  // Edge direction allowed by the mode
  always_comb
  begin
    req_set = 1'b0;
    if (char_q == tdc_pkg::TDC_CHAR_RUNNING)
    begin
      if (measure_mode_i == tdc_pkg::TDC_MODE_BIAS)
      begin
        req_set = edge_sm;
      end
      else if (measure_mode_i == tdc_pkg::TDC_MODE_END)
      begin
        req_set = edge_ms;
      end
      else if (is_peak)
      begin
        req_set = edge_sm | edge_ms;
      end
    end
  end

  // Cleared when the first stage rises, while the decades stand still
  assign req_clear = (gated_tick & ~countdown_first_stage_q) | stop_hit;

  // A new edge in the clearing cycle is kept
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      transition_request_ff_q <= 1'b0;
    end
    else if (req_set)
    begin
      transition_request_ff_q <= 1'b1;
    end
    else if (req_clear)
    begin
      transition_request_ff_q <= 1'b0;
    end
  end

  // Restrictions on a transfer; early is the half stage high
  assign start_block = (bit_count_q == tdc_pkg::BIT_PRESET);
  assign window_ok = (transition_sel_i == tdc_pkg::SEL_ALL) |
                     (bit_count_q == (transition_sel_i - 4'h1));
  assign dir_ok = ~((measure_mode_i == tdc_pkg::TDC_MODE_PEAK_EARLY) & ~half_bit_stage) &
                  ~((measure_mode_i == tdc_pkg::TDC_MODE_PEAK_LATE) & half_bit_stage);
  assign peak_ok = ~is_peak | ~peak_gate_flag_q;
  assign transfer = gated_tick & ~countdown_first_stage_q & transition_request_ff_q &
                    ~start_block & window_ok & dir_ok & peak_ok;

  // ----------------------------------------------------------------
  // Capture register
  // ----------------------------------------------------------------

  // Meter reset and calibrate win over a capture in the same cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      capture_q <= tdc_pkg::REG_ZERO;
    end
    else if (cal_sync_q[SYNC_STAGES-1])
    begin
      capture_q <= tdc_pkg::REG_ZERO;
      capture_q[tdc_pkg::REG_FORTY_POS] <= 1'b1;
    end
    else if (zero_sync_q[SYNC_STAGES-1])
    begin
      capture_q <= tdc_pkg::REG_ZERO;
    end
    else if (transfer && half_bit_stage)
    begin
      capture_q <= {half_bit_stage, ~count_low};
    end
    else if (transfer)
    begin
      capture_q <= {half_bit_stage, count_low};
    end
  end

  // Registered percent reading, one cycle behind the stages
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pct_q <= 7'h00;
    end
    else
    begin
      pct_q <= tdc_pkg::stage_weight(capture_q[6:0]);
    end
  end

  // ----------------------------------------------------------------
  // Peak logic
  // ----------------------------------------------------------------
  assign early_eq = half_bit_stage & (count_low == ~capture_q[6:0]);
  assign late_eq = ~half_bit_stage & (count_low == capture_q[6:0]);

  // Halves exclude each other, so set and clear never collide
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      peak_gate_flag_q <= 1'b0;
    end
    else if (early_eq)
    begin
      peak_gate_flag_q <= 1'b1;
    end
    else if (late_eq)
    begin
      peak_gate_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Indicators and outputs
  // ----------------------------------------------------------------

  // Marking and spacing lamps only mean something for bias and end readings
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      marking_q <= 1'b0;
      spacing_q <= 1'b0;
      mark_q <= 1'b1;
      capture_q_pulse <= 1'b0;
    end
    else
    begin
      marking_q <= (measure_mode_i == tdc_pkg::TDC_MODE_BIAS) ? capture_q[tdc_pkg::REG_HALF_POS]
                   : (measure_mode_i == tdc_pkg::TDC_MODE_END) &
                   ~capture_q[tdc_pkg::REG_HALF_POS];
      spacing_q <= (measure_mode_i == tdc_pkg::TDC_MODE_BIAS) ? ~capture_q[tdc_pkg::REG_HALF_POS]
                   : (measure_mode_i == tdc_pkg::TDC_MODE_END) &
                   capture_q[tdc_pkg::REG_HALF_POS];
      mark_q <= line_now;
      capture_q_pulse <= transfer;
    end
  end

  assign capture_reg_o = capture_q;
  assign distortion_pct_o = pct_q;
  assign marking_o = marking_q;
  assign spacing_o = spacing_q;
  assign signal_mark_o = mark_q;
  assign running_o = (char_q == tdc_pkg::TDC_CHAR_RUNNING);
  assign peak_gate_o = peak_gate_flag_q;
  assign capture_o = capture_q_pulse;

endmodule : tdc_capture

// ### test/tdc_line_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Telegraph line source, idles at mark
// ----------------------------------------------------------------
module tdc_line_model
(
  input wire logic clk_i,
  output logic line_o
);
  initial line_o = 1'b1;

  // One start-stop character; boundary si moved by sh clocks.
  // Stop lasts only one bit, so the timer must stop in time.
  task automatic char_tx(input int bitc, input int n, input logic [9:0] d, input int si,
    input int sh);
    int j;
    for (int t = 0; t < (n + 2) * bitc; t++)
    begin
      j = 0;
      for (int i = 1; i <= n + 1; i++)
        if (t >= i * bitc + ((i == si) ? sh : 0))
          j = i;
      @(posedge clk_i);
      #1;
      line_o = (j == 0) ? 1'b0 : (j > n) ? 1'b1 : d[j - 1];
    end
  endtask : char_tx
endmodule : tdc_line_model

// ### test/tdc_capture_properties.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port-level checks of the capture core
// ----------------------------------------------------------------
module tdc_capture_properties
#(
  parameter int SYNC_STAGES = 2
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic line_mark_i,
  input wire logic [1:0] speed_sel_i,
  input wire logic baud50_i,
  input wire logic [1:0] code_level_i,
  input wire logic [3:0] transition_sel_i,
  input wire logic [2:0] measure_mode_i,
  input wire logic meter_zero_i,
  input wire logic meter_cal_i,
  input wire logic [7:0] capture_reg_o,
  input wire logic [6:0] distortion_pct_o,
  input wire logic marking_o,
  input wire logic spacing_o,
  input wire logic signal_mark_o,
  input wire logic running_o,
  input wire logic peak_gate_o,
  input wire logic capture_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Own meter decode, independent of the design
  function automatic logic [6:0] wsum(input logic [6:0] s);
    return 7'(s[0] + 2 * s[1] + 4 * s[2] + 2 * s[3] + 10 * s[4] + 20 * s[5] + 40 * s[6]);
  endfunction : wsum

  // Repeat counts allow two sync flops plus the load
  a_cal_forty: assert property (meter_cal_i[*5] |-> capture_reg_o == 8'h40)
    else $error("calibrate did not give forty");
  a_zero_clear: assert property ((meter_zero_i && !meter_cal_i)[*5] |-> capture_reg_o == 8'h00)
    else $error("zero did not clear register");
  a_pct_decode: assert property (distortion_pct_o == wsum($past(capture_reg_o[6:0])))
    else $error("percent does not match register");
  a_capture_single: assert property (capture_o |=> !capture_o)
    else $error("capture pulse too long");
  a_bias_lamps: assert property ((measure_mode_i == 3'h0 && $stable(measure_mode_i)
    && !$past(rst_i)) |-> marking_o == $past(capture_reg_o[7]) && spacing_o != marking_o)
    else $error("bias lamps wrong");
  a_end_lamps: assert property ((measure_mode_i == 3'h1 && $stable(measure_mode_i)
    && !$past(rst_i)) |-> spacing_o == $past(capture_reg_o[7]) && spacing_o != marking_o)
    else $error("end lamps wrong");
  a_peak_dark: assert property ((measure_mode_i inside {3'h2, 3'h3, 3'h4}
    && $stable(measure_mode_i)) |-> !marking_o && !spacing_o)
    else $error("lamps lit in peak mode");
  a_signal_sync: assert property ($stable(line_mark_i)[*4] |=> signal_mark_o == $past(line_mark_i))
    else $error("signal indicator wrong");
  a_start_runs: assert property ((!running_o && $fell(line_mark_i)) ##1 (!line_mark_i)[*6]
    |-> running_o)
    else $error("start edge did not start timer");
  a_idle_quiet: assert property ((!running_o)[*3] |-> !capture_o)
    else $error("capture while stopped");

  // Main scenarios reached
  c_capture: cover property (capture_o);
  c_start: cover property ($rose(running_o));
  c_peak_gate: cover property ($rose(peak_gate_o));
  c_marking: cover property (marking_o);
endmodule : tdc_capture_properties

bind tdc_capture tdc_capture_properties #(.SYNC_STAGES(SYNC_STAGES)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .line_mark_i(line_mark_i), .speed_sel_i(speed_sel_i),
  .baud50_i(baud50_i), .code_level_i(code_level_i), .transition_sel_i(transition_sel_i),
  .measure_mode_i(measure_mode_i), .meter_zero_i(meter_zero_i), .meter_cal_i(meter_cal_i),
  .capture_reg_o(capture_reg_o), .distortion_pct_o(distortion_pct_o), .marking_o(marking_o),
  .spacing_o(spacing_o), .signal_mark_o(signal_mark_o), .running_o(running_o),
  .peak_gate_o(peak_gate_o), .capture_o(capture_o));

// ### test/tb.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Bench for the distortion capture core
// ----------------------------------------------------------------
module tb;
  localparam logic [3:0] DIG [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  logic clk_i;
  logic rst_i;
  logic line_mark;
  logic [1:0] speed_sel;
  logic baud50;
  logic [1:0] code_level;
  logic [3:0] transition_sel;
  logic [2:0] measure_mode;
  logic meter_zero;
  logic meter_cal;
  logic [7:0] capture_reg;
  logic [6:0] distortion_pct;
  logic marking;
  logic spacing;
  logic signal_mark;
  logic running;
  logic peak_gate;
  logic capture;
  int num_errors = 0;
  int tests_run = 0;
  int caps = 0;
  int run_cnt = 0;
  int last_run = 0;
  int exp_pct = 0;
  logic exp_half = 1'b0;

  // 25 MHz oscillator
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  tdc_line_model u_line (.clk_i(clk_i), .line_o(line_mark));

  tdc_capture #(.SYNC_STAGES(2)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .line_mark_i(line_mark), .speed_sel_i(speed_sel),
    .baud50_i(baud50), .code_level_i(code_level), .transition_sel_i(transition_sel),
    .measure_mode_i(measure_mode), .meter_zero_i(meter_zero), .meter_cal_i(meter_cal),
    .capture_reg_o(capture_reg), .distortion_pct_o(distortion_pct), .marking_o(marking),
    .spacing_o(spacing), .signal_mark_o(signal_mark), .running_o(running),
    .peak_gate_o(peak_gate), .capture_o(capture));

  // Count capture pulses and timer run lengths
  always @(posedge clk_i)
  begin
    if (capture === 1'b1)
      caps++;
    if (running === 1'b1)
      run_cnt++;
    else if (run_cnt != 0)
    begin
      last_run = run_cnt;
      run_cnt = 0;
    end
  end

  // Hang guard at 150 thousand cycles, well past the expected seventy-eight thousand
  initial
  begin
    #6000000;
    num_errors++;
    stop_test();
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // Tolerance covers divider phase against the start edge
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp,
    input int tol);
    tests_run++;
    if ($isunknown(seen) || seen > exp + tol || seen + tol < exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : check

  function automatic logic [6:0] enc(input logic [6:0] p);
    return {DIG[p / 10][2:0], DIG[p % 10]};
  endfunction : enc

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // One character at 400 clocks a bit; only boundary si is in the window
  task automatic run_row(input int mode, input int si, input int p, input bit early);
    logic [6:0] lv;
    logic ok;
    int c0;
    lv = 7'h4A;
    ok = lv[si] != lv[si - 1] && (mode != 0 || lv[si]) && (mode != 1 || !lv[si]) && mode < 5;
    if ((mode == 3 && !early) || (mode == 4 && early) || (mode >= 2 && p <= exp_pct))
      ok = 1'b0;
    measure_mode = 3'(mode);
    transition_sel = 4'(si);
    c0 = caps;
    u_line.char_tx(400, 5, 10'h005, si, early ? -(4 * p + 2) : 4 * p + 2);
    check("captures", caps - c0, ok, 0);
    if (ok)
    begin
      exp_pct = p;
      exp_half = early;
    end
    check("percent", distortion_pct, exp_pct, 1);
    check("half stage", capture_reg[7], exp_half, 0);
    check("stage code", capture_reg[6:0], enc(distortion_pct), 0);
    if (mode < 2)
      check("marking", marking, (mode == 1) ^ exp_half, 0);
    $display("test mode %0d transition %0d done", mode, si);
  endtask : run_row

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int sp [4] = '{0, 1, 2, 0};
    int cl [4] = '{3, 1, 0, 0};
    int per;
    rst_i = 1'b1;
    speed_sel = 2'h0;
    baud50 = 1'b0;
    code_level = 2'h0;
    transition_sel = 4'h0;
    measure_mode = 3'h0;
    meter_zero = 1'b0;
    meter_cal = 1'b0;
    void'($urandom(59521));
    tick(16);
    rst_i = 1'b0;
    tick(4);
    run_row(0, 3, 12, 0);
    run_row(0, 2, 20, 1);
    run_row(0, 1, 7, 1);
    run_row(0, 3, $urandom_range(30, 3), 0);
    run_row(1, 4, 25, 0);
    run_row(1, 3, 5, 1);
    run_row(5, 3, 30, 0);
    // Calibrate wins over zero while both are held
    meter_cal = 1'b1;
    tick(6);
    check("cal reg", capture_reg, 8'h40, 0);
    meter_zero = 1'b1;
    tick(6);
    check("cal pct", distortion_pct, 7'h28, 0);
    meter_cal = 1'b0;
    tick(6);
    check("zero reg", capture_reg, 8'h00, 0);
    meter_zero = 1'b0;
    exp_pct = 0;
    exp_half = 1'b0;
    $display("test meter reset done");
    run_row(2, 2, 10, 0);
    run_row(2, 3, 5, 1);
    run_row(2, 4, 15, 1);
    run_row(3, 1, 30, 0);
    run_row(3, 3, 20, 1);
    run_row(4, 2, 35, 1);
    run_row(4, 6, 33, 0);
    // Timer length for speeds, the 50 baud divider and code levels
    for (int k = 0; k < 4; k++)
    begin
      speed_sel = 2'(sp[k]);
      baud50 = (k == 3);
      code_level = 2'(cl[k]);
      per = (k == 3) ? 12 : 2 << sp[k];
      u_line.char_tx(200 * per, 5 + cl[k], 10'h000, 0, 0);
      check("run length", last_run, (13 + 2 * cl[k]) * 100 * per, 4 * per + 8);
      $display("test timer %0d done", k);
    end
    stop_test();
  end
endmodule : tb
